// ---- srx_serdes_rx.sv ----
// serdes receive control registers, code group sync and lane alignment
`timescale 1ns/1ps
`default_nettype none
`include "srx_consts.svh"
module srx_serdes_rx #(
  parameter int LANES = 8,
  parameter int EDEPTH = 8,
  parameter int FDEPTH = 32
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [9:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // pll and cdr analog side
  input wire logic PLL_LOCKED,
  input wire logic PLL_CAL_DONE,
  input wire logic PLL_BAND_HIGH,
  input wire logic PLL_BAND_LOW,
  output logic PLL_ENABLE,
  output logic PLL_RECAL,
  output logic [1:0] SYNTH_DIVIDER_SETTING,
  output logic [2:0] REFERENCE_DIVIDE_FACTOR,
  output logic CDR_HALF_SPEED,
  output logic CDR_DOUBLE_SAMPLING,
  output logic CDR_RESET,
  output logic EQ_LOW_POWER,
  output logic SERDES_IRQ,
  // lanes, four decoded bytes each per cycle
  input wire logic [LANES*32-1:0] LANE_DATA,
  input wire logic [LANES*4-1:0] LANE_K,
  input wire logic [LANES-1:0] LANE_ENABLE,
  input wire logic DUAL_LINK,
  input wire logic LMFC_EDGE,
  input wire logic LINK_REINIT,
  output logic LINK0_SYNC_REQUEST_N,
  output logic LINK1_SYNC_REQUEST_N,
  output logic ALIGNED,
  // aligned word stream
  output logic [LANES*32-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY
);
  localparam int W = `SRX_BYTES_PER_PCLK * 8; // lane word per cycle
  localparam int EAW = $clog2(EDEPTH);
  // lane bits per processing cycle equals reference divide ratio
  localparam int LINE_BITS_PER_PCLK = `SRX_BITS_PER_BYTE * `SRX_BYTES_PER_PCLK;
  localparam bit RATIO_OK = LINE_BITS_PER_PCLK == `SRX_REF_DIVIDE;

  // software visible registers
  logic [7:0] irq_enable_serdes_q;
  logic [7:0] irq_status_serdes_q;
  logic [7:0] irq_status_serdes_d;
  logic [7:0] cdr_reset_control_q;
  logic [7:0] cdr_sampling_config_q;
  logic [7:0] equalizer_config_q;
  logic [7:0] synth_control_q;
  logic [7:0] synth_divider_select_q;
  logic [7:0] rdata_q;
  logic recal_q, eq_low_q, irq_q, lock_prev_q;
  logic [2:0] ref_div_q;
  logic lock_rise, lock_fall, wr_st;
  logic [7:0] synth_status;

  // lane and link status
  logic [LANES-1:0] lane_synced, lane_started, lane_ovf, lane_open;
  logic [LANES-1:0] lane_first_r; // lane shows /R/ at the common read pointer, or is unused
  logic [LANES*W-1:0] lane_word;
  logic [LANES-1:0] mask [2];
  logic [1:0] link_synced, sync_n;
  logic relink, all_started, pop;
  logic aligned_q;
  logic [EAW:0] rptr_q;

  srx_stream_if #(.WIDTH(LANES*W)) fin ();
  srx_stream_if #(.WIDTH(LANES*W)) fout ();

  // plain register writes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_enable_serdes_q <= `SRX_REG_RESET;
      cdr_reset_control_q <= `SRX_REG_RESET;
      equalizer_config_q <= `SRX_REG_RESET;
      synth_control_q <= `SRX_REG_RESET;
      synth_divider_select_q <= `SRX_REG_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `SRX_ADDR_IRQ_EN: irq_enable_serdes_q <= REG_WDATA;
        `SRX_ADDR_CDR_RST: cdr_reset_control_q <= REG_WDATA;
        `SRX_ADDR_EQ_CFG: equalizer_config_q <= REG_WDATA;
        `SRX_ADDR_SYN_CTL: synth_control_q <= REG_WDATA;
        `SRX_ADDR_SYN_DIV: synth_divider_select_q <= REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  // cdr mode: half rate wins, so both modes are never selected at once
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cdr_sampling_config_q <= `SRX_REG_RESET;
    end else if (REG_WR && REG_ADDR == `SRX_ADDR_CDR_CFG) begin
      cdr_sampling_config_q <= REG_WDATA;
      if (REG_WDATA[`SRX_BIT_HALF]) begin
        cdr_sampling_config_q[`SRX_BIT_OVS] <= 1'b0;
      end
    end
  end

  // recalibration: a write moving bit 2 from 0 to 1 fires one pulse
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      recal_q <= 1'b0;
    end else begin
      recal_q <= REG_WR && REG_ADDR == `SRX_ADDR_SYN_CTL && REG_WDATA[`SRX_BIT_RECAL]
        && !synth_control_q[`SRX_BIT_RECAL];
    end
  end

  // equalizer mode and reference divide factor decodes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      eq_low_q <= 1'b0;
      ref_div_q <= `SRX_DIV_BY_4;
    end else begin
      eq_low_q <= equalizer_config_q[7:6] == `SRX_EQ_LOW_POWER;
      case (synth_divider_select_q[1:0])
        `SRX_DIV_CODE_OVS: ref_div_q <= `SRX_DIV_BY_1;
        `SRX_DIV_CODE_FULL: ref_div_q <= `SRX_DIV_BY_2;
        default: ref_div_q <= `SRX_DIV_BY_4;
      endcase
    end
  end

  // lock edges and write one to clear status; a new event beats the clear
  assign lock_rise = PLL_LOCKED && !lock_prev_q;
  assign lock_fall = !PLL_LOCKED && lock_prev_q;
  assign wr_st = REG_WR && REG_ADDR == `SRX_ADDR_IRQ_ST;
  always_comb begin
    irq_status_serdes_d = 8'h00;
    irq_status_serdes_d[`SRX_BIT_IRQ_LOCK] = (irq_status_serdes_q[`SRX_BIT_IRQ_LOCK]
      && !(wr_st && REG_WDATA[`SRX_BIT_IRQ_LOCK]))
      || (lock_rise && irq_enable_serdes_q[`SRX_BIT_IRQ_LOCK]);
    irq_status_serdes_d[`SRX_BIT_IRQ_LOST] = (irq_status_serdes_q[`SRX_BIT_IRQ_LOST]
      && !(wr_st && REG_WDATA[`SRX_BIT_IRQ_LOST]))
      || (lock_fall && irq_enable_serdes_q[`SRX_BIT_IRQ_LOST]);
  end

  // interrupt status and request line
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_prev_q <= 1'b0;
      irq_status_serdes_q <= `SRX_REG_RESET;
      irq_q <= 1'b0;
    end else begin
      lock_prev_q <= PLL_LOCKED;
      irq_status_serdes_q <= irq_status_serdes_d;
      irq_q <= |irq_status_serdes_d;
    end
  end

  // pll status as seen by software
  assign synth_status = {2'b00, PLL_BAND_LOW, PLL_BAND_HIGH, PLL_CAL_DONE, 2'b00, PLL_LOCKED};

  // read data, unmapped addresses read zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `SRX_ADDR_IRQ_EN: rdata_q <= irq_enable_serdes_q;
        `SRX_ADDR_IRQ_ST: rdata_q <= irq_status_serdes_q;
        `SRX_ADDR_CDR_RST: rdata_q <= cdr_reset_control_q;
        `SRX_ADDR_CDR_CFG: rdata_q <= cdr_sampling_config_q;
        `SRX_ADDR_EQ_CFG: rdata_q <= equalizer_config_q;
        `SRX_ADDR_SYN_CTL: rdata_q <= synth_control_q;
        `SRX_ADDR_SYN_ST: rdata_q <= synth_status;
        `SRX_ADDR_SYN_DIV: rdata_q <= synth_divider_select_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA = rdata_q;
  assign PLL_ENABLE = synth_control_q[`SRX_BIT_PLL_EN];
  assign PLL_RECAL = recal_q;
  assign SYNTH_DIVIDER_SETTING = synth_divider_select_q[1:0];
  assign REFERENCE_DIVIDE_FACTOR = ref_div_q;
  assign CDR_HALF_SPEED = cdr_sampling_config_q[`SRX_BIT_HALF];
  assign CDR_DOUBLE_SAMPLING = cdr_sampling_config_q[`SRX_BIT_OVS];
  assign CDR_RESET = cdr_reset_control_q[`SRX_BIT_CDR_RST];
  assign EQ_LOW_POWER = eq_low_q;
  assign SERDES_IRQ = irq_q;

  // lane membership: single link uses every enabled lane for both outputs
  always_comb begin
    mask[0] = LANE_ENABLE;
    mask[1] = LANE_ENABLE;
    for (int i = 0; i < LANES; i++) begin
      if (DUAL_LINK) begin
        mask[0][i] = LANE_ENABLE[i] && (i < LANES / 2);
        mask[1][i] = LANE_ENABLE[i] && (i >= LANES / 2);
      end
    end
  end

  // an elastic overflow means the link lost its alignment
  assign relink = LINK_REINIT || (|lane_ovf);
  assign all_started = (|LANE_ENABLE) && (&(lane_started | ~LANE_ENABLE));
  assign pop = aligned_q && fin.ready; // downstream stall holds the buffers

  // per lane code group sync and elastic buffer
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [W-1:0] d;
    logic [3:0] k;
    logic [2:0] kcnt_q, kcnt_d;
    logic sync_q, start_q, last_a_q, r_first, wr;
    logic [EAW:0] wptr_q;
    logic [W-1:0] mem [EDEPTH]; // holds early lanes until the last one starts
    assign d = LANE_DATA[g*W +: W];
    assign k = LANE_K[g*4 +: 4];
    assign lane_open[g] = (DUAL_LINK && g >= LANES / 2) ? sync_n[1] : sync_n[0];

    // count consecutive commas in byte order; once four are seen the count holds,
    // so a non-comma later in the same word cannot undo a completed run
    always_comb begin
      kcnt_d = kcnt_q;
      for (int b = 0; b < 4; b++) begin
        if (k[b] && d[b*8 +: 8] == `SRX_K_COMMA) begin
          if (kcnt_d != `SRX_KCOUNT_SYNC) begin
            kcnt_d = kcnt_d + 3'h1;
          end
        end else if (!sync_q && kcnt_d != `SRX_KCOUNT_SYNC) begin
          kcnt_d = 3'h0;
        end
      end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        kcnt_q <= 3'h0;
        sync_q <= 1'b0;
      end else if (relink) begin
        kcnt_q <= 3'h0;
        sync_q <= 1'b0;
      end else begin
        kcnt_q <= kcnt_d;
        sync_q <= kcnt_d == `SRX_KCOUNT_SYNC;
      end
    end

    // first word of the second multiframe follows the closing /A/
    assign r_first = last_a_q && k[0] && d[7:0] == `SRX_K_LANE_START;
    assign wr = start_q || (sync_q && lane_open[g] && r_first);

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        last_a_q <= 1'b0;
        start_q <= 1'b0;
        wptr_q <= '0;
      end else if (relink) begin
        last_a_q <= 1'b0;
        start_q <= 1'b0;
        wptr_q <= '0;
      end else begin
        last_a_q <= k[3] && d[31:24] == `SRX_K_MF_END;
        start_q <= wr;
        if (wr) begin
          wptr_q <= wptr_q + 1'b1;
        end
      end
    end

    always_ff @(posedge CLK) begin
      if (wr) begin
        mem[wptr_q[EAW-1:0]] <= d;
      end
    end

    assign lane_synced[g] = sync_q;
    assign lane_started[g] = start_q;
    assign lane_ovf[g] = start_q && !pop && (wptr_q - rptr_q) == (EAW + 1)'(EDEPTH);
    assign lane_word[g*W +: W] = mem[rptr_q[EAW-1:0]];
    assign lane_first_r[g] = !LANE_ENABLE[g] || lane_word[g*W +: 8] == `SRX_K_LANE_START;
  end

  // common read side releases every lane together
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aligned_q <= 1'b0;
      rptr_q <= '0;
    end else if (relink) begin
      aligned_q <= 1'b0;
      rptr_q <= '0;
    end else begin
      aligned_q <= all_started;
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  assign fin.valid = aligned_q;
  assign fin.data = lane_word;
  assign fout.ready = OUT_READY;
  assign OUT_VALID = fout.valid;
  assign OUT_DATA = fout.data;
  assign ALIGNED = aligned_q;
  assign LINK0_SYNC_REQUEST_N = sync_n[0];
  assign LINK1_SYNC_REQUEST_N = sync_n[1];

  srx_stream_fifo #(.WIDTH(LANES*W), .DEPTH(FDEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(RESET_N),
    .push(fin),
    .pop(fout)
  );

  // per link sync request state machine
  for (genvar l = 0; l < 2; l++) begin : g_link
    srx_pkg::srx_link_state_e state_q;
    logic sn_q;
    assign link_synced[l] = (|mask[l]) && (&(lane_synced | ~mask[l]));
    assign sync_n[l] = sn_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        state_q <= srx_pkg::SRX_SYNC_REQ;
        sn_q <= 1'b0;
      end else if (relink) begin
        state_q <= srx_pkg::SRX_SYNC_REQ;
        sn_q <= 1'b0;
      end else begin
        case (state_q)
          srx_pkg::SRX_SYNC_REQ: begin
            if (link_synced[l]) begin
              state_q <= srx_pkg::SRX_WAIT_LMFC;
            end
          end
          srx_pkg::SRX_WAIT_LMFC: begin
            if (LMFC_EDGE) begin
              state_q <= srx_pkg::SRX_WAIT_ILAS;
              sn_q <= 1'b1;
            end
          end
          srx_pkg::SRX_WAIT_ILAS: begin
            if (aligned_q) begin
              state_q <= srx_pkg::SRX_STREAM;
            end
          end
          srx_pkg::SRX_STREAM: begin
          end
          default: state_q <= srx_pkg::SRX_SYNC_REQ;
        endcase
      end
    end

    sequence s_ready_at_lmfc;
      state_q == srx_pkg::SRX_WAIT_LMFC && LMFC_EDGE && !relink;
    endsequence
    sync_release_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      s_ready_at_lmfc |=> sn_q ##1 (sn_q || $past(relink)))
      else $error("sync request not released at lmfc edge");
    sync_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(sn_q) |-> $past(LMFC_EDGE) && $past(link_synced[l]))
      else $error("sync request released early");
  end

  eq_mode_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    equalizer_config_q[7:6] == 2'b01 |=> EQ_LOW_POWER)
    else $error("equalizer not in low power mode");
  status_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_RD && REG_ADDR == `SRX_ADDR_SYN_ST |=> REG_RDATA[0] == $past(PLL_LOCKED)
    && REG_RDATA[3] == $past(PLL_CAL_DONE) && REG_RDATA[5] == $past(PLL_BAND_LOW))
    else $error("pll status read wrong");
  recal_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PLL_RECAL |-> $past(synth_control_q[2]) == 1'b0 ##1 !PLL_RECAL)
    else $error("recalibration pulse wrong");
  lock_irq_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    lock_rise && irq_enable_serdes_q[3] |=> irq_status_serdes_q[3] && SERDES_IRQ)
    else $error("lock interrupt not raised");
  irq_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    !irq_enable_serdes_q[2] && !irq_status_serdes_q[2] |=> !irq_status_serdes_q[2])
    else $error("lost interrupt set while disabled");
  irq_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_st && REG_WDATA[3] && !lock_rise |=> !irq_status_serdes_q[3])
    else $error("lock interrupt not cleared");
  cdr_mode_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    !(CDR_HALF_SPEED && CDR_DOUBLE_SAMPLING))
    else $error("half rate and oversampling both set");
  lane_release_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(aligned_q) |-> (&lane_first_r) && RATIO_OK)
    else $error("lanes released before all aligned");
endmodule
`default_nettype wire

// ---- srx_consts.svh ----
// constants for the serdes receive clocking and link sync block
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH
// register offsets
`define SRX_ADDR_IRQ_EN 10'h01f
`define SRX_ADDR_IRQ_ST 10'h023
`define SRX_ADDR_CDR_RST 10'h206
`define SRX_ADDR_CDR_CFG 10'h230
`define SRX_ADDR_EQ_CFG 10'h268
`define SRX_ADDR_SYN_CTL 10'h280
`define SRX_ADDR_SYN_ST 10'h281
`define SRX_ADDR_SYN_DIV 10'h289
// reset value of every writable register
`define SRX_REG_RESET 8'h00
// field positions
`define SRX_BIT_IRQ_LOCK 3
`define SRX_BIT_IRQ_LOST 2
`define SRX_BIT_PLL_EN 0
`define SRX_BIT_RECAL 2
`define SRX_BIT_HALF 5
`define SRX_BIT_OVS 1
`define SRX_BIT_CDR_RST 0
`define SRX_EQ_LOW_POWER 2'h1
// divider codes and factors
`define SRX_DIV_CODE_OVS 2'h2
`define SRX_DIV_CODE_FULL 2'h1
`define SRX_DIV_CODE_HALF 2'h0
`define SRX_DIV_BY_1 3'h1
`define SRX_DIV_BY_2 3'h2
`define SRX_DIV_BY_4 3'h4
// control characters
`define SRX_K_COMMA 8'hbc
`define SRX_K_LANE_START 8'h1c
`define SRX_K_MF_END 8'h7c
`define SRX_KCOUNT_SYNC 3'h4
// clock relationships
`define SRX_BITS_PER_BYTE 10
`define SRX_BYTES_PER_PCLK 4
`define SRX_REF_DIVIDE 40
`define SRX_PFD_MIN_MHZ 35
`define SRX_PFD_MAX_MHZ 80
`endif

// ---- srx_pkg.sv ----
// types shared by the receive link modules
package srx_pkg;
  // per link synchronisation state
  typedef enum logic [1:0] {
    SRX_SYNC_REQ,
    SRX_WAIT_LMFC,
    SRX_WAIT_ILAS,
    SRX_STREAM
  } srx_link_state_e;
endpackage

// ---- srx_stream_if.sv ----
// valid/ready stream carrier between the link logic and its fifo
`timescale 1ns/1ps
`default_nettype none
interface srx_stream_if #(parameter int WIDTH = 32) ();
  logic valid; // word offered
  logic ready; // word accepted
  logic [WIDTH-1:0] data; // word
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- srx_stream_fifo.sv ----
// synchronous stream fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module srx_stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // streams
  srx_stream_if.sink push,
  srx_stream_if.source pop
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage, depth a power of two
  logic [AW:0] wptr_q; // write pointer with wrap bit
  logic [AW:0] rptr_q; // read pointer with wrap bit
  logic full, empty, do_wr, do_rd;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  assign empty = wptr_q == rptr_q;
  assign full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign push.ready = !full;
  assign do_wr = push.valid && !full;
  // refill the output stage when it is empty or being taken
  assign do_rd = !empty && (!out_valid_q || pop.ready);
  assign pop.valid = out_valid_q;
  assign pop.data = out_data_q;

  // storage has no reset, pointers and output stage do
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wptr_q[AW-1:0]] <= push.data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (do_wr) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (do_rd) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  // output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (do_rd) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem[rptr_q[AW-1:0]];
    end else if (pop.ready) begin
      out_valid_q <= 1'b0;
    end
  end

  held_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid_q && !pop.ready |=> out_valid_q && $stable(out_data_q))
    else $error("fifo output dropped while stalled");
  no_overrun_a: assert property (@(posedge clk) disable iff (!rst_n)
    full |=> !(wptr_q == rptr_q))
    else $error("fifo lost words when full");
endmodule
`default_nettype wire

// ---- srx_tx_model.sv ----
// lane transmitter model: commas while sync is requested, then skewed alignment
`timescale 1ns/1ps
`default_nettype none
module srx_tx_model #(
  parameter int LANES = 8
) (
  // clock
  input wire logic clk,
  // sync request and fault switch
  input wire logic sync_n,
  input wire logic short_comma,
  // decoded lanes, byte0 earliest
  output logic [LANES*32-1:0] lane_data,
  output logic [LANES*4-1:0] lane_k
);
  int cnt = 0; // cycles since sync was released
  int n; // word index from the start marker
  initial begin
    lane_data = '0;
    lane_k = '0;
  end
  // lane g starts g/2 cycles late so the elastic buffers must absorb skew
  always @(posedge clk) begin
    cnt <= (sync_n === 1'b1) ? cnt + 1 : 0;
    for (int g = 0; g < LANES; g++) begin
      n = cnt - g / 2 - 8; // first ilas multiframe: eight words ending in /A/
      if (sync_n !== 1'b1) begin
        // the fault switch drops the flag on byte3 so four never line up
        lane_data[g*32+:32] <= 32'hbcbc_bcbc;
        lane_k[g*4+:4] <= short_comma ? 4'h7 : 4'hf;
      end else if (n < -1) begin
        lane_data[g*32+:32] <= 32'h0000_0000; // filler
        lane_k[g*4+:4] <= 4'h0;
      end else if (n == -1) begin
        lane_data[g*32+:32] <= 32'h7c00_0000; // marker in the last byte
        lane_k[g*4+:4] <= 4'h8;
      end else begin
        // /A/ also closes multiframes two to four, so the ilas is four long
        lane_data[g*32+:32] <= {(n % 8 == 7 && n < 24) ? 8'h7c : 8'(g), 16'(n), n == 0 ? 8'h1c : 8'h00};
        lane_k[g*4+:4] <= {n % 8 == 7 && n < 24, 2'h0, n == 0};
      end
    end
  end
endmodule
`default_nettype wire

// ---- srx_tb.sv ----
// self-checking bench for the serdes receive block
`timescale 1ns/1ps
`default_nettype none
`include "srx_consts.svh"
module testbench;
  localparam logic [9:0] REGS [8] = '{`SRX_ADDR_IRQ_EN, `SRX_ADDR_IRQ_ST, `SRX_ADDR_CDR_RST,
    `SRX_ADDR_CDR_CFG, `SRX_ADDR_EQ_CFG, `SRX_ADDR_SYN_CTL, `SRX_ADDR_SYN_ST, `SRX_ADDR_SYN_DIV};
  logic clk = 1'b0; // 100 ns period
  logic reset_n = 1'b0;
  logic [9:0] addr = 10'h000; // register port
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0;
  logic [7:0] rdata;
  logic locked = 1'b0, cal = 1'b0, hi = 1'b0, lo = 1'b0; // pll status levels
  logic pll_en, recal, half, dbl, cdr_rst, eq_lp, irq;
  logic [1:0] div;
  logic [2:0] fac;
  logic [255:0] lane_data, out_data;
  logic [31:0] lane_k;
  logic [2:0] lcnt = 3'h0; // lmfc every eight cycles
  logic lmfc = 1'b0, reinit = 1'b0;
  logic dual_link = 1'b0; // both links share one set of link settings
  logic short_comma = 1'b1; // transmitter starts with broken commas
  logic sync0, sync1, aligned, out_valid;
  logic out_ready = 1'b0;
  logic s0_prev = 1'b0, lm_prev = 1'b0; // one cycle back
  int n_errors = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  // free running multiframe edge
  always @(posedge clk) begin
    lcnt <= lcnt + 3'h1;
    lmfc <= lcnt == 3'h7;
  end

  srx_serdes_rx dut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .PLL_LOCKED(locked), .PLL_CAL_DONE(cal), .PLL_BAND_HIGH(hi),
    .PLL_BAND_LOW(lo), .PLL_ENABLE(pll_en), .PLL_RECAL(recal), .SYNTH_DIVIDER_SETTING(div),
    .REFERENCE_DIVIDE_FACTOR(fac), .CDR_HALF_SPEED(half), .CDR_DOUBLE_SAMPLING(dbl),
    .CDR_RESET(cdr_rst), .EQ_LOW_POWER(eq_lp), .SERDES_IRQ(irq), .LANE_DATA(lane_data),
    .LANE_K(lane_k), .LANE_ENABLE(8'hff), .DUAL_LINK(dual_link), .LMFC_EDGE(lmfc), .LINK_REINIT(reinit),
    .LINK0_SYNC_REQUEST_N(sync0), .LINK1_SYNC_REQUEST_N(sync1), .ALIGNED(aligned),
    .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(out_ready));

  srx_tx_model #(.LANES(8)) tx (.clk(clk), .sync_n(sync0), .short_comma(short_comma),
    .lane_data(lane_data), .lane_k(lane_k));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask

  // read data is valid one cycle after the strobe edge
  task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), {24'h0, exp}, {24'h0, rdata});
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a sync release must come one edge after an lmfc pulse
  always @(negedge clk) begin
    if (!s0_prev && sync0 === 1'b1) chk("lmfc before release", 32'h1, {31'h0, lm_prev});
    s0_prev <= sync0 === 1'b1;
    lm_prev <= lmfc;
  end

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (REGS[i]) reg_rd(REGS[i], 8'h00);
    reg_wr(10'h3ff, 8'hff);
    reg_rd(10'h3ff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_wr(`SRX_ADDR_EQ_CFG, 8'(i << 6));
      reg_rd(`SRX_ADDR_EQ_CFG, 8'(i << 6));
      chk("eq low power", 32'(i == 1), {31'h0, eq_lp});
      reg_wr(`SRX_ADDR_SYN_DIV, 8'(i));
      reg_rd(`SRX_ADDR_SYN_DIV, 8'(i));
      chk("divide factor", i == 2 ? 32'h1 : i == 1 ? 32'h2 : 32'h4, {29'h0, fac});
      chk("divider code", 32'(i), {30'h0, div});
      reg_wr(`SRX_ADDR_CDR_CFG, 8'((i & 2) << 4 | (i & 1) << 1));
      chk("cdr mode", {30'h0, i[1], i == 1}, {30'h0, half, dbl});
    end
    // divider code to match half rate, then enable and recalibrate
    reg_wr(`SRX_ADDR_SYN_DIV, 8'h00);
    reg_wr(`SRX_ADDR_SYN_CTL, 8'h01);
    chk("pll enable", 32'h1, {31'h0, pll_en});
    reg_wr(`SRX_ADDR_SYN_CTL, 8'h05);
    chk("recal", 32'h1, {31'h0, recal});
    @(negedge clk);
    chk("recal", 32'h0, {31'h0, recal});
    reg_wr(`SRX_ADDR_CDR_RST, 8'h01);
    chk("cdr reset", 32'h1, {31'h0, cdr_rst});
    reg_wr(`SRX_ADDR_CDR_RST, 8'h00);
    chk("cdr reset", 32'h0, {31'h0, cdr_rst});
    // status bits; lock rises while its event is disabled
    @(posedge clk);
    locked <= 1'b1;
    cal <= 1'b1;
    hi <= 1'b1;
    reg_rd(`SRX_ADDR_SYN_ST, 8'h19);
    reg_rd(`SRX_ADDR_IRQ_ST, 8'h00);
    @(posedge clk);
    hi <= 1'b0;
    lo <= 1'b1;
    reg_wr(`SRX_ADDR_SYN_ST, 8'h00);
    reg_rd(`SRX_ADDR_SYN_ST, 8'h29);
    reg_wr(`SRX_ADDR_IRQ_EN, 8'h0c);
    @(posedge clk);
    locked <= 1'b0;
    reg_rd(`SRX_ADDR_IRQ_ST, 8'h04);
    chk("irq line", 32'h1, {31'h0, irq});
    reg_wr(`SRX_ADDR_IRQ_ST, 8'h04);
    chk("irq line", 32'h0, {31'h0, irq});
    @(posedge clk);
    locked <= 1'b1;
    reg_rd(`SRX_ADDR_IRQ_ST, 8'h08);
    // broken commas must never end the request
    repeat (40) @(negedge clk);
    chk("sync held", 32'h0, {30'h0, sync1, sync0});
    @(posedge clk);
    short_comma <= 1'b0;
    for (int i = 0; i < 100 && sync0 !== 1'b1; i++) @(negedge clk);
    chk("sync released", 32'h3, {30'h0, sync1, sync0});
    for (int i = 0; i < 100 && aligned !== 1'b1; i++) @(negedge clk);
    chk("aligned", 32'h1, {31'h0, aligned});
    // words come out lane-aligned from the start marker on, consumer slow
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < 20 && out_valid !== 1'b1; i++) @(negedge clk);
      for (int g = 0; g < 8; g++) begin
        chk("lane word", {8'(g), 16'(n), n == 0 ? 8'h1c : 8'h00}, out_data[g*32+:32]);
      end
      @(posedge clk);
      out_ready <= 1'b1;
      @(posedge clk);
      out_ready <= 1'b0;
      @(negedge clk);
    end
    // stall until the fifo refuses and the elastic buffers overflow
    @(posedge clk);
    short_comma <= 1'b1;
    repeat (60) @(negedge clk);
    chk("overflow relink", 32'h0, {30'h0, aligned, sync0});
    @(posedge clk);
    out_ready <= 1'b1;
    for (int i = 0; i < 100 && out_valid !== 1'b0; i++) @(negedge clk);
    chk("drained", 32'h0, {31'h0, out_valid});
    @(posedge clk);
    short_comma <= 1'b0;
    for (int i = 0; i < 200 && aligned !== 1'b1; i++) @(negedge clk);
    chk("realigned", 32'h3, {30'h0, sync0, aligned});
    @(posedge clk);
    reinit <= 1'b1;
    short_comma <= 1'b1;
    @(posedge clk);
    reinit <= 1'b0;
    repeat (2) @(negedge clk);
    chk("reinit request", 32'h0, {30'h0, sync1, sync0});
    // dual link: each half of the lanes releases its own request
    @(posedge clk);
    dual_link <= 1'b1;
    short_comma <= 1'b0;
    for (int i = 0; i < 100 && sync1 !== 1'b1; i++) @(negedge clk);
    chk("dual release", 32'h3, {30'h0, sync1, sync0});
    tally_and_finish();
  end

  // the run takes a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
